// ===== dv/lta_link_train_checker.sv
// checker: port-level assertions for the link training port
`timescale 1ns/1ps
`default_nettype none
module lta_link_train_checker #(
	parameter int unsigned MAX_WAIT_CYCLES = 2000
) (
	input wire logic       REF_CLK,
	input wire logic       RSTN,
	input wire logic       TRAIN_ENABLE_IN,
	input wire logic       TRAIN_RESTART_IN,
	input wire logic [3:0] TRAINING_DONE_FLAG,
	input wire logic [3:0] TRAINING_ACTIVE_FLAG,
	input wire logic [3:0] TRAINING_TIMEOUT_FLAG,
	input wire logic [3:0] RX_FRAME_START_PULSE,
	input wire logic [3:0] TX_FRAME_START_PULSE,
	input wire logic [3:0] FRAME_SYNC_FLAG
);
	wire logic [3:0] act, dn, fl, rsof;
	wire logic       en, rs;
	int unsigned     cnt_r;
	int unsigned     cnt_nxt;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// short aliases for the flags, the rx frame start pulse and the enable and restart inputs
	assign act = TRAINING_ACTIVE_FLAG;
	assign dn = TRAINING_DONE_FLAG;
	assign fl = TRAINING_TIMEOUT_FLAG;
	assign rsof = RX_FRAME_START_PULSE;
	assign en = TRAIN_ENABLE_IN;
	assign rs = TRAIN_RESTART_IN;
	// cycles lane 0 has trained since its last fresh start
	assign cnt_nxt = (!act[0] || (en && rs)) ? 0 : cnt_r + 1;
	always_ff @(posedge REF_CLK) begin
		cnt_r <= RSTN ? cnt_nxt : 0;
	end
	a_disable_mission: assert property (
		(!en)[*3] |-> (act | dn | fl) == 4'h0) else $error("trained while off");
	a_restart_fresh: assert property (
		en && rs |-> ##[1:2] (act == 4'hF && (dn | fl) == 4'h0))
		else $error("restart did not restart");
	a_state_exclusive: assert property (
		((act & dn) | (act & fl) | (dn & fl)) == 4'h0) else $error("two states");
	a_rx_sof_single: assert property (
		|rsof |=> (rsof & $past(rsof)) == 4'h0) else $error("rx sof too long");
	a_tx_frame_period: assert property (@(posedge REF_CLK)
		disable iff (!RSTN || rs) (!rs)[*5] ##0 TX_FRAME_START_PULSE[0]
		|-> ##112 (TX_FRAME_START_PULSE[0] || !act[0]))
		else $error("tx frame spacing");
	a_sync_needs_train: assert property (
		(act == 4'h0)[*3] |-> FRAME_SYNC_FLAG == 4'h0) else $error("stale sync");
	a_timeout_bound: assert property (
		cnt_r <= MAX_WAIT_CYCLES + 2) else $error("no timeout");
	a_timeout_late: assert property (
		$rose(fl[0]) |-> cnt_r + 3 >= MAX_WAIT_CYCLES) else $error("early fail");
	// main scenarios
	cover property ($rose(dn[0]));
	cover property ($rose(fl[0]));
	cover property ($rose(FRAME_SYNC_FLAG[0]));
endmodule
bind lta_link_train lta_link_train_checker #(
	.MAX_WAIT_CYCLES(MAX_WAIT_CYCLES)
) u_checker (.*);
`default_nettype wire

// ===== dv/lta_partner.sv
// lta_partner: far-end link partner sending training frames on all lanes
`timescale 1ns/1ps
`default_nettype none
module lta_partner (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic [63:0] ctl_blk,
	input  wire logic [63:0] sts_blk,
	output var  logic [3:0]  rx_data
);
	import lta_pkg::*;
	int pos_r;
	// marker, control, status, filler, msb first; idle line flips
	always @(posedge clk) begin
		for (int l = 0; l < 4; l++) begin
			if (!rst_n)
				rx_data[l] <= 1'b0;
			else if (!run)
				rx_data[l] <= ~rx_data[l];
			else if (pos_r < 16)
				rx_data[l] <= FRAME_MARKER[15 - pos_r];
			else if (pos_r < 32)
				rx_data[l] <= ctl_blk[l*16 + 31 - pos_r];
			else if (pos_r < 48)
				rx_data[l] <= sts_blk[l*16 + 47 - pos_r];
			else
				rx_data[l] <= pos_r[0];
		end
		if (!rst_n || !run || pos_r == FRAME_BITS - 1)
			pos_r <= 0;
		else
			pos_r <= pos_r + 1;
	end
endmodule
`default_nettype wire

// ===== dv/test_lta_link_train.sv
// test_lta_link_train: self-checking bench for the link training port
`timescale 1ns/1ps
`default_nettype none
module test_lta_link_train;
	import lta_pkg::*;
	localparam int MAXW = 2000;
	logic        REF_CLK, RSTN, TRAIN_ENABLE_IN, TRAIN_RESTART_IN;
	logic [3:0]  RX_SIDE_DONE_IN, PRESET_BIT_OUT_FRAME, INIT_BIT_OUT_FRAME;
	logic [3:0]  MISSION_TX_DATA, LANE_RX_DATA, LANE_TX_DATA;
	logic [3:0]  TRAINING_DONE_FLAG, TRAINING_ACTIVE_FLAG, FRAME_SYNC_FLAG;
	logic [3:0]  TRAINING_TIMEOUT_FLAG, RX_FRAME_START_PULSE;
	logic [3:0]  TX_FRAME_START_PULSE, PRESET_BIT_RECEIVED, INIT_BIT_RECEIVED;
	logic [43:0] PATTERN_SEED_LANE;
	logic [7:0]  POST_TAP_REQUEST_OUT, MAIN_TAP_REQUEST_OUT;
	logic [7:0]  PRE_TAP_REQUEST_OUT, POST_TAP_STATUS_OUT;
	logic [7:0]  MAIN_TAP_STATUS_OUT, PRE_TAP_STATUS_OUT;
	logic [7:0]  POST_TAP_REQUEST_RECEIVED, MAIN_TAP_REQUEST_RECEIVED;
	logic [7:0]  PRE_TAP_REQUEST_RECEIVED, POST_TAP_STATUS_RECEIVED;
	logic [7:0]  MAIN_TAP_STATUS_RECEIVED, PRE_TAP_STATUS_RECEIVED;
	logic        part_run;
	logic [63:0] p_ctl, p_sts;
	int          err_count, total_checks;

	lta_link_train #(.MAX_WAIT_CYCLES(MAXW)) DUT (.*);
	lta_partner u_partner (.clk(REF_CLK), .rst_n(RSTN), .run(part_run),
		.ctl_blk(p_ctl), .sts_blk(p_sts), .rx_data(LANE_RX_DATA));

	// free-running reference clock
	initial begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end

	task automatic tick;
		@(posedge REF_CLK);
		#1;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// expected outgoing blocks of one lane
	function automatic logic [15:0] ctl_of(int l);
		return {2'b00, PRESET_BIT_OUT_FRAME[l], INIT_BIT_OUT_FRAME[l], 6'h00,
			POST_TAP_REQUEST_OUT[l*2 +: 2], MAIN_TAP_REQUEST_OUT[l*2 +: 2],
			PRE_TAP_REQUEST_OUT[l*2 +: 2]};
	endfunction
	function automatic logic [15:0] sts_of(int l);
		return {RX_SIDE_DONE_IN[l], 9'h000, POST_TAP_STATUS_OUT[l*2 +: 2],
			MAIN_TAP_STATUS_OUT[l*2 +: 2], PRE_TAP_STATUS_OUT[l*2 +: 2]};
	endfunction

	// disabled: lanes pass mission data, no training
	task automatic t_mission;
		for (int k = 0; k < 2; k++) begin
			@(posedge REF_CLK) MISSION_TX_DATA <= k ? 4'h5 : 4'hA;
			repeat (4) tick;
			check(LANE_TX_DATA, k ? 4'h5 : 4'hA);
			check({TRAINING_ACTIVE_FLAG, TRAINING_DONE_FLAG}, 8'h00);
		end
		@(posedge REF_CLK) begin
			TRAIN_ENABLE_IN <= 1'b1;
			part_run <= 1'b1;
		end
	endtask

	// capture one outgoing frame on every lane
	task automatic t_tx;
		logic [111:0] fr [4];
		for (int i = 0; i < 300 && TX_FRAME_START_PULSE[0] !== 1'b1; i++) tick;
		check(TX_FRAME_START_PULSE, 4'hF);
		for (int b = 111; b >= 0; b--) begin
			for (int l = 0; l < 4; l++) fr[l][b] = LANE_TX_DATA[l];
			tick;
		end
		check(TX_FRAME_START_PULSE, 4'hF);
		for (int l = 0; l < 4; l++) begin
			check(fr[l][111:80], {FRAME_MARKER, ctl_of(l)});
			check(fr[l][79:64], sts_of(l));
		end
		check(fr[0][63:0] === fr[1][63:0], 1'b1);
		check(fr[0][63:0] !== fr[2][63:0], 1'b1);
	endtask

	// lock to the partner and read back its fields
	task automatic t_rx;
		int n;
		n = 0;
		for (int i = 0; i < 800 && FRAME_SYNC_FLAG !== 4'hF; i++) tick;
		check(FRAME_SYNC_FLAG, 4'hF);
		for (int i = 0; i < 224; i++) begin
			if (RX_FRAME_START_PULSE[0] === 1'b1) n++;
			tick;
		end
		check(n, 2);
		for (int l = 0; l < 4; l++) begin
			check({PRESET_BIT_RECEIVED[l], INIT_BIT_RECEIVED[l],
				POST_TAP_REQUEST_RECEIVED[l*2 +: 2],
				MAIN_TAP_REQUEST_RECEIVED[l*2 +: 2],
				PRE_TAP_REQUEST_RECEIVED[l*2 +: 2]},
				{p_ctl[l*16+13], p_ctl[l*16+12], p_ctl[l*16 +: 6]});
			check({POST_TAP_STATUS_RECEIVED[l*2 +: 2],
				MAIN_TAP_STATUS_RECEIVED[l*2 +: 2],
				PRE_TAP_STATUS_RECEIVED[l*2 +: 2]}, p_sts[l*16 +: 6]);
		end
	endtask

	// receivers trained: lanes finish and resume mission data
	task automatic t_done;
		@(posedge REF_CLK) begin
			RX_SIDE_DONE_IN <= 4'hF;
			MISSION_TX_DATA <= 4'h6;
		end
		for (int i = 0; i < 300 && TRAINING_DONE_FLAG !== 4'hF; i++) tick;
		check({TRAINING_DONE_FLAG, TRAINING_ACTIVE_FLAG}, 8'hF0);
		repeat (3) tick;
		check(LANE_TX_DATA, 4'h6);
	endtask

	// restart from the finished state
	task automatic t_restart;
		@(posedge REF_CLK) TRAIN_RESTART_IN <= 1'b1;
		@(posedge REF_CLK) TRAIN_RESTART_IN <= 1'b0;
		repeat (2) tick;
		check({TRAINING_DONE_FLAG, TRAINING_ACTIVE_FLAG}, 8'h0F);
	endtask

	// silent partner: training runs out of time
	task automatic t_timeout;
		@(posedge REF_CLK) begin
			part_run <= 1'b0;
			RX_SIDE_DONE_IN <= 4'h0;
			TRAIN_RESTART_IN <= 1'b1;
		end
		@(posedge REF_CLK) TRAIN_RESTART_IN <= 1'b0;
		for (int i = 0; i < MAXW + 300 && TRAINING_TIMEOUT_FLAG !== 4'hF; i++)
			tick;
		check({TRAINING_TIMEOUT_FLAG, TRAINING_ACTIVE_FLAG, FRAME_SYNC_FLAG},
			12'hF00);
	endtask

	// enable dropped from the failed state: back to mission mode
	task automatic t_disable;
		@(posedge REF_CLK) begin
			TRAIN_ENABLE_IN <= 1'b0;
			MISSION_TX_DATA <= 4'h9;
		end
		repeat (3) tick;
		check({TRAINING_TIMEOUT_FLAG, TRAINING_ACTIVE_FLAG,
			TRAINING_DONE_FLAG}, 12'h000);
		check(LANE_TX_DATA, 4'h9);
	endtask

	// main sequence
	initial begin
		RSTN = 1'b0;
		TRAIN_ENABLE_IN = 1'b0;
		TRAIN_RESTART_IN = 1'b0;
		RX_SIDE_DONE_IN = 4'h0;
		PRESET_BIT_OUT_FRAME = 4'h5;
		INIT_BIT_OUT_FRAME = 4'h3;
		MISSION_TX_DATA = 4'h0;
		PATTERN_SEED_LANE = {11'h7FF, 11'h13C, 11'h2A5, 11'h2A5};
		POST_TAP_REQUEST_OUT = 8'h24;
		MAIN_TAP_REQUEST_OUT = 8'h49;
		PRE_TAP_REQUEST_OUT = 8'h92;
		POST_TAP_STATUS_OUT = 8'hE4;
		MAIN_TAP_STATUS_OUT = 8'h1B;
		PRE_TAP_STATUS_OUT = 8'h4E;
		part_run = 1'b0;
		p_ctl = {16'h0008, 16'h3024, 16'h1011, 16'h2006};
		p_sts = {16'h8006, 16'h8039, 16'h8024, 16'h801B};
		err_count = 0;
		total_checks = 0;
		repeat (4) @(posedge REF_CLK);
		RSTN <= 1'b1;
		t_mission;
		t_tx;
		t_rx;
		t_done;
		t_restart;
		t_timeout;
		t_disable;
		report_and_stop;
	end

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge REF_CLK);
		err_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire

// ===== rtl/lta_frame_rx.sv
// lta_frame_rx: finds, locks to and unpacks one lane's training frames
`timescale 1ns/1ps
`default_nettype none
module lta_frame_rx (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     run,
	input  wire logic                     ser_in,
	output var  logic                     lock,
	output var  logic                     sof,
	output var  logic [lta_pkg::BLK_W-1:0] ctrl_blk,
	output var  logic [lta_pkg::BLK_W-1:0] stat_blk
);
	import lta_pkg::*;

	logic [2*BLK_W-1:0] sh_r;
	logic [POS_W-1:0]   pos_r;
	logic [1:0]         hits_r;
	wire                hit;
	wire                on_time;
	wire                accept;
	wire                gain;
	wire                miss;

	// marker search: hunt anywhere, then only at the expected place
	assign hit = sh_r[MARK_W-1:0] == FRAME_MARKER;
	assign on_time = pos_r == POS_W'(FRAME_BITS);
	assign accept = hit && (!lock || on_time);
	assign gain = !lock && accept && on_time &&
		hits_r == 2'(LOCK_HITS - 1);
	assign miss = lock && on_time && !hit;

	// shift register, position counter and lock state
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			sh_r <= '0;
			pos_r <= '0;
			hits_r <= '0;
			lock <= 1'b0;
			sof <= 1'b0;
			ctrl_blk <= '0;
			stat_blk <= '0;
		end else begin
			sh_r <= {sh_r[2*BLK_W-2:0], ser_in};
			if (accept)
				pos_r <= POS_W'(1); // first bit after the marker is bit one
			else if (pos_r != '1)
				pos_r <= pos_r + 1'b1;
			if (accept && !lock)
				hits_r <= on_time ? hits_r + 1'b1 : 2'h1;
			else if (miss)
				hits_r <= '0;
			if (gain)
				lock <= 1'b1;
			else if (miss)
				lock <= 1'b0;
			sof <= accept && (lock || gain);
			if (lock && pos_r == POS_W'(2 * BLK_W)) begin
				ctrl_blk <= sh_r[2*BLK_W-1:BLK_W];
				stat_blk <= sh_r[BLK_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/lta_frame_tx.sv
// lta_frame_tx: serialises one lane's training frames
`timescale 1ns/1ps
`default_nettype none
module lta_frame_tx (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      run,
	input  wire logic [lta_pkg::BLK_W-1:0]  ctrl_blk,
	input  wire logic [lta_pkg::BLK_W-1:0]  stat_blk,
	input  wire logic [lta_pkg::SEED_W-1:0] seed,
	output var  logic                      ser_out,
	output var  logic                      sof
);
	import lta_pkg::*;

	logic [POS_W-1:0]    cnt_r;
	logic [HDR_BITS-1:0] hdr_r;
	logic [SEED_W-1:0]   prbs_r;
	wire                 first;
	wire                 last;
	wire                 in_hdr;
	wire                 bit_nxt;
	wire                 fb;
	wire  [SEED_W-1:0]   seed_ok;

	// frame position decode and pattern feedback
	assign first = cnt_r == '0;
	assign last = cnt_r == POS_W'(FRAME_BITS - 1);
	assign in_hdr = cnt_r < POS_W'(HDR_BITS);
	assign fb = prbs_r[10] ^ prbs_r[8];
	assign seed_ok = (seed == '0) ? SEED_ZERO_FIX : seed; // all-zero locks up
	assign bit_nxt = first ? FRAME_MARKER[MARK_W-1] :
		in_hdr ? hdr_r[HDR_BITS-1] : prbs_r[SEED_W-1];

	// header shift, pattern generator and frame counter
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			cnt_r <= '0;
			hdr_r <= '0;
			prbs_r <= seed_ok;
			ser_out <= 1'b0;
			sof <= 1'b0;
		end else begin
			cnt_r <= last ? '0 : cnt_r + 1'b1;
			sof <= first;
			ser_out <= bit_nxt;
			if (first)
				hdr_r <= {FRAME_MARKER[MARK_W-2:0], ctrl_blk, stat_blk,
					1'b0};
			else
				hdr_r <= {hdr_r[HDR_BITS-2:0], 1'b0};
			if (!in_hdr)
				prbs_r <= {prbs_r[SEED_W-2:0], fb};
		end
	end
endmodule
`default_nettype wire

// ===== rtl/lta_link_train.sv
// lta_link_train: four-lane link training port, top level
`timescale 1ns/1ps
`default_nettype none
module lta_link_train #(
	parameter int unsigned MAX_WAIT_CYCLES = int'(lta_pkg::MAX_WAIT_CYC)
) (
	input  wire logic REF_CLK,
	input  wire logic RSTN,
	// control side
	input  wire logic TRAIN_ENABLE_IN,
	input  wire logic TRAIN_RESTART_IN,
	input  wire logic [lta_pkg::LANES-1:0] RX_SIDE_DONE_IN,
	input  wire logic [lta_pkg::LANES-1:0] PRESET_BIT_OUT_FRAME,
	input  wire logic [lta_pkg::LANES-1:0] INIT_BIT_OUT_FRAME,
	input  wire logic [lta_pkg::LANES*lta_pkg::SEED_W-1:0]
		PATTERN_SEED_LANE,
	input  wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		POST_TAP_REQUEST_OUT,
	input  wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		MAIN_TAP_REQUEST_OUT,
	input  wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		PRE_TAP_REQUEST_OUT,
	input  wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		POST_TAP_STATUS_OUT,
	input  wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		MAIN_TAP_STATUS_OUT,
	input  wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		PRE_TAP_STATUS_OUT,
	// lane serial data
	input  wire logic [lta_pkg::LANES-1:0] MISSION_TX_DATA,
	input  wire logic [lta_pkg::LANES-1:0] LANE_RX_DATA,
	output wire logic [lta_pkg::LANES-1:0] LANE_TX_DATA,
	// status side
	output wire logic [lta_pkg::LANES-1:0] TRAINING_DONE_FLAG,
	output wire logic [lta_pkg::LANES-1:0] TRAINING_ACTIVE_FLAG,
	output wire logic [lta_pkg::LANES-1:0] TRAINING_TIMEOUT_FLAG,
	output wire logic [lta_pkg::LANES-1:0] RX_FRAME_START_PULSE,
	output wire logic [lta_pkg::LANES-1:0] TX_FRAME_START_PULSE,
	output wire logic [lta_pkg::LANES-1:0] FRAME_SYNC_FLAG,
	output wire logic [lta_pkg::LANES-1:0] PRESET_BIT_RECEIVED,
	output wire logic [lta_pkg::LANES-1:0] INIT_BIT_RECEIVED,
	output wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		POST_TAP_REQUEST_RECEIVED,
	output wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		MAIN_TAP_REQUEST_RECEIVED,
	output wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		PRE_TAP_REQUEST_RECEIVED,
	output wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		POST_TAP_STATUS_RECEIVED,
	output wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		MAIN_TAP_STATUS_RECEIVED,
	output wire logic [lta_pkg::LANES*lta_pkg::TAP_W-1:0]
		PRE_TAP_STATUS_RECEIVED
);
	import lta_pkg::*;

	localparam logic [WAIT_W-1:0] WAIT_LAST =
		WAIT_W'(MAX_WAIT_CYCLES - 1);

	// one training engine per lane
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		lta_state_t         st_r;
		lta_state_t         st_nxt;
		logic [WAIT_W-1:0]  tmr_r;
		logic [WAIT_W-1:0]  tmr_nxt;
		logic               done_r;
		logic               active_r;
		logic               fail_r;
		logic               txd_r;
		logic               txsof_r;
		wire                tx_run;
		wire                rx_run;
		wire                tx_ser;
		wire                tx_sof;
		wire                rx_lock;
		wire                rx_sof;
		wire  [BLK_W-1:0]   ctrl_out;
		wire  [BLK_W-1:0]   stat_out;
		wire  [BLK_W-1:0]   ctrl_in;
		wire  [BLK_W-1:0]   stat_in;
		wire                partner_ready;
		wire                trained;
		wire                timed_out;
		wire                restart;

		// outgoing blocks from the control inputs
		assign ctrl_out = build_ctrl(
			PRESET_BIT_OUT_FRAME[l],
			INIT_BIT_OUT_FRAME[l],
			POST_TAP_REQUEST_OUT[l*TAP_W +: TAP_W],
			MAIN_TAP_REQUEST_OUT[l*TAP_W +: TAP_W],
			PRE_TAP_REQUEST_OUT[l*TAP_W +: TAP_W]);
		assign stat_out = build_stat(
			RX_SIDE_DONE_IN[l],
			POST_TAP_STATUS_OUT[l*TAP_W +: TAP_W],
			MAIN_TAP_STATUS_OUT[l*TAP_W +: TAP_W],
			PRE_TAP_STATUS_OUT[l*TAP_W +: TAP_W]);

		// completion and timeout decode
		assign partner_ready = stat_in[STS_READY_BIT];
		assign trained = rx_lock && partner_ready &&
			RX_SIDE_DONE_IN[l];
		assign timed_out = tmr_r == WAIT_LAST;
		assign restart = TRAIN_ENABLE_IN && TRAIN_RESTART_IN;
		// restart also clears both frame engines so training starts afresh
		assign tx_run = st_r == ST_TRAIN && !restart;
		assign rx_run = st_r == ST_TRAIN && !restart;

		// lane training state machine
		always_comb begin
			st_nxt = st_r;
			tmr_nxt = tmr_r;
			unique case (st_r)
				ST_MISSION: begin
					tmr_nxt = '0;
					if (TRAIN_ENABLE_IN)
						st_nxt = ST_TRAIN;
				end
				ST_TRAIN: begin
					tmr_nxt = tmr_r + 1'b1;
					if (trained)
						st_nxt = ST_SEND_DATA;
					else if (timed_out)
						st_nxt = ST_FAIL;
				end
				ST_SEND_DATA: begin
					tmr_nxt = '0;
				end
				ST_FAIL: begin
					tmr_nxt = '0;
				end
			endcase
			if (restart) begin
				st_nxt = ST_TRAIN;
				tmr_nxt = '0;
			end
			if (!TRAIN_ENABLE_IN) begin
				st_nxt = ST_MISSION;
				tmr_nxt = '0;
			end
		end

		// state, timer and flag registers
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				st_r <= ST_MISSION;
				tmr_r <= '0;
				done_r <= 1'b0;
				active_r <= 1'b0;
				fail_r <= 1'b0;
			end else begin
				st_r <= st_nxt;
				tmr_r <= tmr_nxt;
				done_r <= st_nxt == ST_SEND_DATA;
				active_r <= st_nxt == ST_TRAIN;
				fail_r <= st_nxt == ST_FAIL;
			end
		end

		// lane output: training frames while training, else mission
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				txd_r <= 1'b0;
				txsof_r <= 1'b0;
			end else begin
				txd_r <= tx_run ? tx_ser : MISSION_TX_DATA[l];
				txsof_r <= tx_run && tx_sof;
			end
		end

		lta_frame_tx u_tx (
			.clk      (REF_CLK),
			.rst_n    (RSTN),
			.run      (tx_run),
			.ctrl_blk (ctrl_out),
			.stat_blk (stat_out),
			.seed     (PATTERN_SEED_LANE[l*SEED_W +: SEED_W]),
			.ser_out  (tx_ser),
			.sof      (tx_sof)
		);

		lta_frame_rx u_rx (
			.clk      (REF_CLK),
			.rst_n    (RSTN),
			.run      (rx_run),
			.ser_in   (LANE_RX_DATA[l]),
			.lock     (rx_lock),
			.sof      (rx_sof),
			.ctrl_blk (ctrl_in),
			.stat_blk (stat_in)
		);

		// status outputs, all straight from flip-flops
		assign LANE_TX_DATA[l] = txd_r;
		assign TX_FRAME_START_PULSE[l] = txsof_r;
		assign TRAINING_DONE_FLAG[l] = done_r;
		assign TRAINING_ACTIVE_FLAG[l] = active_r;
		assign TRAINING_TIMEOUT_FLAG[l] = fail_r;
		assign RX_FRAME_START_PULSE[l] = rx_sof;
		assign FRAME_SYNC_FLAG[l] = rx_lock;
		assign PRESET_BIT_RECEIVED[l] = ctrl_in[CTL_PRESET_BIT];
		assign INIT_BIT_RECEIVED[l] = ctrl_in[CTL_INIT_BIT];

		// received tap fields
		assign POST_TAP_REQUEST_RECEIVED[l*TAP_W +: TAP_W] =
			tap_of(ctrl_in, CTL_POST_LSB);
		assign MAIN_TAP_REQUEST_RECEIVED[l*TAP_W +: TAP_W] =
			tap_of(ctrl_in, CTL_MAIN_LSB);
		assign PRE_TAP_REQUEST_RECEIVED[l*TAP_W +: TAP_W] =
			tap_of(ctrl_in, CTL_PRE_LSB);
		assign POST_TAP_STATUS_RECEIVED[l*TAP_W +: TAP_W] =
			tap_of(stat_in, STS_POST_LSB);
		assign MAIN_TAP_STATUS_RECEIVED[l*TAP_W +: TAP_W] =
			tap_of(stat_in, STS_MAIN_LSB);
		assign PRE_TAP_STATUS_RECEIVED[l*TAP_W +: TAP_W] =
			tap_of(stat_in, STS_PRE_LSB);
	end
endmodule
`default_nettype wire

// ===== rtl/lta_pkg.sv
// lta_pkg: constants, types and field helpers for the link training port
// Function
// - enable low: lanes stay in mission mode
// - restart input restarts training from any state
// - preset input sent in outgoing control block
// - initialize input sent in outgoing control block
// - each lane pattern seeded from own input
// - three tap requests sent in control block
// - three tap statuses sent in status block
// - done flag set in send-data state
// - active flag set while lane trains
// - failure flag set when training times out
// - received frame start pulses one cycle
// - frame sync flag once receiver locks
// - received preset bit presented per lane
// - received initialize bit presented per lane
// - received tap requests presented per lane
// - received post tap status presented
// - received main, pre tap status presented
// - transmit frame start pulses one cycle
package lta_pkg;
	localparam int LANES = 4;
	localparam int SEED_W = 11;
	localparam int TAP_W = 2;
	localparam int BLK_W = 16;
	localparam int MARK_W = 16;
	localparam int PAT_BITS = 64;
	localparam int HDR_BITS = MARK_W + 2 * BLK_W;
	localparam int FRAME_BITS = HDR_BITS + PAT_BITS;
	localparam int POS_W = 8;
	localparam logic [MARK_W-1:0] FRAME_MARKER = 16'hFF00;
	localparam int LOCK_HITS = 3;
	// control block layout
	localparam int CTL_PRE_LSB = 0;
	localparam int CTL_MAIN_LSB = 2;
	localparam int CTL_POST_LSB = 4;
	localparam int CTL_INIT_BIT = 12;
	localparam int CTL_PRESET_BIT = 13;
	// status block layout
	localparam int STS_PRE_LSB = 0;
	localparam int STS_MAIN_LSB = 2;
	localparam int STS_POST_LSB = 4;
	localparam int STS_READY_BIT = 15;
	// field encodings
	localparam logic [1:0] REQ_HOLD = 2'h0;
	localparam logic [1:0] REQ_INC = 2'h1;
	localparam logic [1:0] REQ_DEC = 2'h2;
	localparam logic [1:0] STS_NOT_UPD = 2'h0;
	localparam logic [1:0] STS_UPDATED = 2'h1;
	localparam logic [1:0] STS_MIN = 2'h2;
	localparam logic [1:0] STS_MAX = 2'h3;
	localparam logic [SEED_W-1:0] SEED_ZERO_FIX = 11'h001;
	// training period limit
	localparam longint CLK_PERIOD_NS = 100;
	localparam longint MAX_WAIT_MS = 500;
	localparam longint MAX_WAIT_CYC =
		MAX_WAIT_MS * 64'd1000000 / CLK_PERIOD_NS;
	localparam int WAIT_W = 23;

	typedef enum logic [1:0] {
		ST_MISSION, ST_TRAIN, ST_SEND_DATA, ST_FAIL
	} lta_state_t;

	// packs outgoing control block
	function automatic logic [BLK_W-1:0] build_ctrl(
		input logic preset, input logic init,
		input logic [1:0] post, input logic [1:0] main,
		input logic [1:0] pre);
		logic [BLK_W-1:0] b;
		b = '0;
		b[CTL_PRESET_BIT] = preset;
		b[CTL_INIT_BIT] = init;
		b[CTL_POST_LSB +: TAP_W] = post;
		b[CTL_MAIN_LSB +: TAP_W] = main;
		b[CTL_PRE_LSB +: TAP_W] = pre;
		return b;
	endfunction

	// packs outgoing status block
	function automatic logic [BLK_W-1:0] build_stat(
		input logic ready, input logic [1:0] post,
		input logic [1:0] main, input logic [1:0] pre);
		logic [BLK_W-1:0] b;
		b = '0;
		b[STS_READY_BIT] = ready;
		b[STS_POST_LSB +: TAP_W] = post;
		b[STS_MAIN_LSB +: TAP_W] = main;
		b[STS_PRE_LSB +: TAP_W] = pre;
		return b;
	endfunction

	// pulls one 2-bit tap field from a block
	function automatic logic [1:0] tap_of(
		input logic [BLK_W-1:0] b, input int lsb);
		return b[lsb +: TAP_W];
	endfunction
endpackage
